// File: hdl/mth_pkg.sv
// Shared constants and types of the modem transmit handshake block.
package mth_pkg;

  // Clock and timer base figures.
  localparam int CLK_PERIOD_NS = 20;
  localparam int TICK_PERIOD_MS = 10;
  localparam int TICK_PERIOD_NS = TICK_PERIOD_MS * 1000000;
  localparam int TICK_CYCLES_DEF = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int TICK_CNT_W = 20;

  // One timer tick expressed in microseconds, the unit of the delay counter.
  localparam logic [23:0] TICK_US = 24'h002710;

  // Longest wait for clear-to-send before a telegram is abandoned (100 ms).
  localparam logic [23:0] CTS_WAIT_US = 24'h0186a0;

  // Register offsets on the plain register port.
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_TIMING = 5'h04;
  localparam logic [4:0] REG_CHAR_US = 5'h08;
  localparam logic [4:0] REG_TX_DATA = 5'h0c;
  localparam logic [4:0] REG_RX_DATA = 5'h10;
  localparam logic [4:0] REG_STATUS = 5'h14;
  localparam logic [4:0] REG_IRQ_STAT = 5'h18;
  localparam logic [4:0] REG_IRQ_MASK = 5'h1c;

  // Field positions.
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_FULL_BIT = 1;
  localparam int TX_LAST_BIT = 8;
  localparam int IRQ_CTS_ERR = 0;
  localparam int IRQ_TGRAM_DONE = 1;
  localparam int IRQ_RX_CHAR = 2;
  localparam int IRQ_W = 3;

  // Reset values.
  localparam logic [15:0] CHAR_US_RST = 16'h22b8;
  localparam logic [7:0] SETTLE_RST = 8'h02;
  localparam logic [7:0] POST_RST = 8'h00;

  // Transmit handshake phases.
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CTS_WAIT,
    ST_SETTLE,
    ST_SEND,
    ST_POST
  } mth_state_type;

endpackage : mth_pkg

// File: hdl/mth_time_if.sv
// Interface joining the handshake core to its tick and delay timers.
`timescale 1ns/1ns
interface mth_time_if;
  import mth_pkg::*;

  logic ce; // Clock enable shared with the core.
  logic load; // Restart pulse for the delay and the tick phase.
  logic [23:0] amount; // Delay to run, in microseconds.
  logic tick; // One-cycle pulse every timer tick.
  logic expired; // Delay finished and no restart pending.

  modport ctl (output ce, output load, output amount, input expired);
  modport gen (input ce, input load, output tick);
  modport cnt (input ce, input load, input amount, input tick,
    output expired);
endinterface : mth_time_if

// File: hdl/mth_tick_gen.sv
// Timer tick generator, restarted whenever a delay is loaded.
`timescale 1ns/1ns
module mth_tick_gen
  import mth_pkg::*;
#(
  parameter logic [TICK_CNT_W-1:0] TICK_CYCLES = TICK_CNT_W'(TICK_CYCLES_DEF)
) (
  // Clock and reset.
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  // Timer link.
  mth_time_if.gen tm
);

  // All state of the tick generator.
  typedef struct packed {
    logic [TICK_CNT_W-1:0] cnt;
    logic tick;
  } mth_tick_type;

  mth_tick_type q, d;

  // Counts clock cycles; a load realigns the phase so delays start whole.
  always_comb begin
    d = q;
    d.tick = 1'b0;
    if (tm.load) begin
      d.cnt = '0;
    end else if (q.cnt == TICK_CYCLES - TICK_CNT_W'(1)) begin
      d.cnt = '0;
      d.tick = 1'b1; // RQ10
    end else begin
      d.cnt = q.cnt + TICK_CNT_W'(1);
    end
  end

  // Registers the state while the clock enable is high.
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      q <= '0;
    end else if (tm.ce) begin
      q <= d;
    end
  end

  assign tm.tick = q.tick;

endmodule : mth_tick_gen

// File: hdl/mth_delay_cnt.sv
// Down-counter that runs a delay in whole timer ticks.
`timescale 1ns/1ns
module mth_delay_cnt
  import mth_pkg::*;
(
  // Clock and reset.
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  // Timer link.
  mth_time_if.cnt tm
);

  // All state of the delay counter.
  typedef struct packed {
    logic [23:0] rem;
    logic done;
  } mth_dly_type;

  mth_dly_type q, d;

  // Removes one tick of time per tick; a partial tick still costs a tick,
  // so the delay is rounded up to whole ticks.
  always_comb begin
    d = q;
    if (tm.load) begin
      d.rem = tm.amount;
      d.done = (tm.amount == '0);
    end else if (tm.tick && !q.done) begin
      if (q.rem <= TICK_US) begin
        d.rem = '0; // RQ13
        d.done = 1'b1;
      end else begin
        d.rem = q.rem - TICK_US; // RQ13
      end
    end
  end

  // Registers the state while the clock enable is high.
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      q <= '0;
    end else if (tm.ce) begin
      q <= d;
    end
  end

  // A pending load hides a stale finish from the previous delay.
  assign tm.expired = q.done && !tm.load;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!arst_n_i);

  // A delay may only finish on a tick or on a load of zero.
  a_tick_quantum: assert property ( // RQ13
    $rose(q.done) |-> $past(tm.tick) || $past(tm.load))
    else $error("Delay finished without a timer tick.");

endmodule : mth_delay_cnt

// File: hdl/mth_core.sv
// Transmit-side modem handshake with register port and timers.
// Functional notes
// RQ1 - Full duplex: request-to-send high after init.
// RQ2 - Full duplex: characters wait for clear-to-send.
// RQ3 - Half duplex: request-to-send framed around telegram.
// RQ4 - Receive side accepts every character always.
// RQ5 - Missing clear-to-send flags error; loop back.
// RQ6 - Duplex mode chosen by control bit.
// RQ7 - Line-settle wait before telegram, after carrier.
// RQ8 - Post-telegram delay after last character.
// RQ9 - Delays count character times at baud.
// RQ10 - Delays timed by a 10 ms tick.
// RQ11 - Own settle exceeds remote post delay.
// RQ12 - Suggested delay settings, tune by experiment.
// RQ13 - Delays round up to ticks, down-count.
// RQ14 - Dropped clear-to-send holds next character.
`timescale 1ns/1ns
module mth_core
  import mth_pkg::*;
#(
  parameter logic [TICK_CNT_W-1:0] TICK_CYCLES = TICK_CNT_W'(TICK_CYCLES_DEF)
) (
  // Clock, reset and clock enable.
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  input wire logic ce_i,
  // Register port.
  input wire logic [4:0] addr_i,
  input wire logic [31:0] wr_data_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rd_data_o,
  // Modem handshake pins.
  output logic rts_o,
  input wire logic cts_i,
  // Character shifter on the transmit side.
  output logic tx_start_o,
  output logic [7:0] tx_data_o,
  input wire logic tx_done_i,
  // Character receiver.
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_data_i,
  // Interrupt.
  output logic irq_o
);

  // All state of the core.
  typedef struct packed {
    logic en; // Initialization done.
    logic full_dup; // Full duplex when set.
    logic [7:0] settle_chr; // Line-settle time in characters.
    logic [7:0] post_chr; // Post-telegram delay in characters.
    logic [15:0] char_us; // One character time in microseconds.
    logic [7:0] tx_char; // Character waiting to be sent.
    logic tx_last; // Waiting character ends the telegram.
    logic slot_full; // A character waits in the slot.
    logic in_flight; // Shifter is sending a character.
    logic last_sent; // The telegram's last character is out.
    logic [7:0] rx_char; // Last received character.
    logic [IRQ_W-1:0] irq_stat; // Sticky event bits.
    logic [IRQ_W-1:0] irq_mask; // Interrupt enables.
    mth_state_type st; // Handshake phase.
    logic rts; // Request-to-send pin.
    logic cts_meta; // First synchroniser stage.
    logic cts; // Synchronised clear-to-send.
    logic tx_start; // Start pulse to the shifter.
    logic [7:0] tx_data; // Character to the shifter.
    logic [31:0] rdata; // Read data, valid one cycle after a read.
    logic irq; // Interrupt pin.
    logic load; // Delay restart pulse.
    logic [23:0] amount; // Delay to run in microseconds.
  } mth_core_type;

  mth_core_type q, d;

  // Timer link shared with the two timer modules.
  mth_time_if tm ();

  // Delay lengths in microseconds for each character-counted delay.
  logic [23:0] settle_us;
  logic [23:0] post_us;
  // Event pulses that feed the sticky status bits.
  logic [IRQ_W-1:0] ev_set;
  // Status bits cleared by the current read.
  logic [IRQ_W-1:0] rd_clr;

  // Character counts scaled by the character time.
  assign settle_us = 24'(q.settle_chr) * 24'(q.char_us); // RQ9
  assign post_us = 24'(q.post_chr) * 24'(q.char_us); // RQ9

  // The next state of the whole core.
  always_comb begin
    d = q;
    ev_set = '0;
    rd_clr = '0;
    d.tx_start = 1'b0;
    d.load = 1'b0;
    d.rdata = '0;

    // Clear-to-send passes two flip-flops before any use.
    d.cts_meta = cts_i;
    d.cts = q.cts_meta;

    // Every received character is taken, whatever the transmit phase.
    if (rx_valid_i) begin
      d.rx_char = rx_data_i; // RQ4
      ev_set[IRQ_RX_CHAR] = 1'b1; // RQ4
    end

    // Register writes.
    if (wr_i) begin
      unique case (addr_i)
        REG_CTRL: begin
          d.en = wr_data_i[CTRL_EN_BIT];
          d.full_dup = wr_data_i[CTRL_FULL_BIT]; // RQ6
        end
        REG_TIMING: begin
          d.settle_chr = wr_data_i[7:0];
          d.post_chr = wr_data_i[15:8];
        end
        REG_CHAR_US: begin
          d.char_us = wr_data_i[15:0];
        end
        REG_TX_DATA: begin
          // A write with the slot full or before init is dropped.
          if (!q.slot_full && q.en) begin
            d.tx_char = wr_data_i[7:0];
            d.tx_last = wr_data_i[TX_LAST_BIT];
            d.slot_full = 1'b1;
          end
        end
        REG_IRQ_MASK: begin
          d.irq_mask = wr_data_i[IRQ_W-1:0];
        end
        default: begin
          // Read-only and unmapped offsets ignore writes.
        end
      endcase
    end

    // Register reads; unmapped offsets read as zero.
    if (rd_i) begin
      unique case (addr_i)
        REG_CTRL: d.rdata = {30'h0, q.full_dup, q.en};
        REG_TIMING: d.rdata = {16'h0, q.post_chr, q.settle_chr};
        REG_CHAR_US: d.rdata = {16'h0, q.char_us};
        REG_RX_DATA: d.rdata = {24'h0, q.rx_char};
        REG_STATUS: d.rdata = {24'h0, 2'h0, q.in_flight, q.st, q.cts,
          !q.slot_full && q.en};
        REG_IRQ_STAT: begin
          d.rdata = {29'h0, q.irq_stat};
          rd_clr = q.irq_stat;
        end
        REG_IRQ_MASK: d.rdata = {29'h0, q.irq_mask};
        default: d.rdata = '0;
      endcase
    end

    // Handshake sequence for one telegram.
    unique case (q.st)
      ST_IDLE: begin
        // The first character of a telegram starts the handshake.
        if (q.slot_full) begin
          d.load = 1'b1;
          d.amount = CTS_WAIT_US;
          d.st = ST_CTS_WAIT;
        end
      end
      ST_CTS_WAIT: begin
        if (q.cts) begin
          // Carrier is up; now let the line settle.
          d.load = 1'b1; // RQ7
          d.amount = settle_us; // RQ7
          d.st = ST_SETTLE;
        end else if (tm.expired) begin
          // No clear-to-send in time: report and drop the character.
          ev_set[IRQ_CTS_ERR] = 1'b1; // RQ5
          d.slot_full = 1'b0;
          d.st = ST_IDLE;
        end
      end
      ST_SETTLE: begin
        if (tm.expired) begin
          d.st = ST_SEND; // RQ7
        end
      end
      ST_SEND: begin
        // A character in the shifter always finishes; the next one
        // waits while clear-to-send is low.
        if (q.slot_full && !q.in_flight && q.cts) begin
          d.tx_start = 1'b1; // RQ2
          d.tx_data = q.tx_char;
          d.in_flight = 1'b1;
          d.slot_full = 1'b0;
          d.last_sent = q.tx_last;
        end else if (q.in_flight && tx_done_i) begin
          d.in_flight = 1'b0; // RQ14
          if (q.last_sent) begin
            d.load = 1'b1; // RQ8
            d.amount = post_us; // RQ8
            d.last_sent = 1'b0;
            d.st = ST_POST;
          end
        end
      end
      ST_POST: begin
        if (tm.expired) begin
          ev_set[IRQ_TGRAM_DONE] = 1'b1; // RQ8
          d.st = ST_IDLE;
        end
      end
    endcase

    // Leaving initialization abandons any telegram in progress.
    if (!d.en) begin
      // No character is started in the cycle that aborts the telegram.
      d.tx_start = 1'b0;
      d.st = ST_IDLE;
      d.slot_full = 1'b0;
      d.in_flight = 1'b0;
      d.last_sent = 1'b0;
    end

    // Request-to-send: steady in full duplex, framed in half duplex.
    d.rts = d.en && (d.full_dup || d.st != ST_IDLE); // RQ1 RQ3

    // A new event wins over the clear of a read in the same cycle.
    d.irq_stat = (q.irq_stat & ~rd_clr) | ev_set;
    d.irq = |(d.irq_stat & d.irq_mask);
  end

  // Registers the whole state while the clock enable is high.
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      q <= '0;
      q.settle_chr <= SETTLE_RST;
      q.post_chr <= POST_RST;
      q.char_us <= CHAR_US_RST;
      q.st <= ST_IDLE;
    end else if (ce_i) begin
      q <= d;
    end
  end

  // Timer link drives.
  assign tm.ce = ce_i;
  assign tm.load = q.load;
  assign tm.amount = q.amount;

  // Tick source for all three delays: clear-to-send wait, line settle and post-telegram.
  mth_tick_gen #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_tick (
    .core_clk_i(core_clk_i),
    .arst_n_i(arst_n_i),
    .tm(tm.gen)
  );

  // Delay down-counter.
  mth_delay_cnt u_dly (
    .core_clk_i(core_clk_i),
    .arst_n_i(arst_n_i),
    .tm(tm.cnt)
  );

  // Outputs straight from flip-flops.
  assign rd_data_o = q.rdata;
  assign rts_o = q.rts;
  assign tx_start_o = q.tx_start;
  assign tx_data_o = q.tx_data;
  assign irq_o = q.irq;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!arst_n_i);

  // A character is handed over with clear-to-send seen high.
  sequence s_char_go;
    ce_i && d.en && q.st == ST_SEND && q.slot_full && !q.in_flight && q.cts;
  endsequence

  // The shifter sees the same character one cycle later.
  sequence s_char_out;
    tx_start_o && tx_data_o == $past(q.tx_char) && q.in_flight;
  endsequence

  a_full_rts_hold: assert property ( // RQ1
    q.en && q.full_dup |-> rts_o)
    else $error("Full duplex request-to-send dropped.");

  a_char_needs_cts: assert property ( // RQ2
    tx_start_o |-> $past(q.cts) && $past(q.st) == ST_SEND)
    else $error("Character started without clear-to-send.");

  a_char_handover: assert property ( // RQ14
    s_char_go |=> s_char_out)
    else $error("Ready character not handed to the shifter.");

  a_half_rts_frame: assert property ( // RQ3
    !q.full_dup |-> rts_o == (q.en && q.st != ST_IDLE))
    else $error("Half duplex request-to-send out of frame.");

  a_rx_always_taken: assert property ( // RQ4
    ce_i && rx_valid_i |=> q.rx_char == $past(rx_data_i)
      && q.irq_stat[IRQ_RX_CHAR])
    else $error("Received character not accepted.");

  a_cts_error_flag: assert property ( // RQ5
    ce_i && q.en && q.st == ST_CTS_WAIT && !q.cts && tm.expired
      |=> q.irq_stat[IRQ_CTS_ERR] && q.st == ST_IDLE)
    else $error("Missing clear-to-send not reported.");

  a_settle_load: assert property ( // RQ9
    ce_i && d.en && q.st == ST_CTS_WAIT && q.cts
      |=> q.load && q.st == ST_SETTLE
      && q.amount == $past(24'(q.settle_chr) * 24'(q.char_us)))
    else $error("Line-settle delay not loaded.");

  a_settle_hold: assert property ( // RQ7
    ce_i && d.en && q.st == ST_SETTLE && !tm.expired |=> q.st == ST_SETTLE)
    else $error("Settle phase left before its delay.");

  a_post_hold: assert property ( // RQ8
    ce_i && d.en && q.st == ST_POST && !tm.expired
      |=> q.st == ST_POST && rts_o)
    else $error("Post-telegram delay cut short.");

endmodule : mth_core

// File: bench/mth_modem_model.sv
// Behavioural modem and character shifter on the far side of the block.
`timescale 1ns/1ns
module mth_modem_model (
  // Clock and reset.
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  // Modem handshake pins.
  input wire logic rts_i,
  output logic cts_o,
  // Character shifter side.
  input wire logic tx_start_i,
  input wire logic [7:0] tx_data_i,
  output logic tx_done_o,
  // Scenario controls and observations.
  input wire logic loop_i,
  input wire logic hold_cts_i,
  output logic [7:0] last_char_o,
  output logic [7:0] sent_o
);
  logic [3:0] busy_q; // Cycles left of the character in flight.

  // The cable loops request-to-send back; the modem may hold it low.
  assign cts_o = loop_i & rts_i & ~hold_cts_i;

  // Each character shifts for a few cycles and then reports done once.
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      busy_q <= 4'h0;
      tx_done_o <= 1'b0;
      last_char_o <= 8'h00;
      sent_o <= 8'h00;
    end else begin
      tx_done_o <= 1'b0;
      if (tx_start_i) begin
        busy_q <= 4'h4;
        last_char_o <= tx_data_i;
        sent_o <= sent_o + 8'h01;
      end else if (busy_q != 4'h0) begin
        busy_q <= busy_q - 4'h1;
        tx_done_o <= (busy_q == 4'h1);
      end
    end
  end
endmodule : mth_modem_model

// File: bench/testbench.sv
// Self-checking testbench of the modem transmit handshake block.
`timescale 1ns/1ns
`define CHK(a, e) check_val(32'(a), 32'(e))
`define WAIT(c) do begin @(posedge core_clk_i); #1; end while (!(c))
module testbench;
  import mth_pkg::*;
  logic core_clk_i, arst_n_i, wr_i, rd_i, rts_o, cts_i, irq_o;
  logic tx_start_o, tx_done_i, rx_valid_i, loop, hold;
  logic [4:0] addr_i;
  logic [31:0] wr_data_i, rd_data_o, rv;
  logic [7:0] tx_data_o, rx_data_i, last_char, sent;
  int mismatches = 0;
  int checked = 0;
  int cycles = 0;
  int t0;

  // Design under test with a short timer tick of 50 cycles.
  mth_core #(.TICK_CYCLES(20'd50)) mth_core_i (.core_clk_i(core_clk_i),
    .arst_n_i(arst_n_i), .ce_i(1'b1), .addr_i(addr_i),
    .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o),
    .rts_o(rts_o), .cts_i(cts_i), .tx_start_o(tx_start_o),
    .tx_data_o(tx_data_o), .tx_done_i(tx_done_i), .rx_valid_i(rx_valid_i),
    .rx_data_i(rx_data_i), .irq_o(irq_o));

  // Far-side modem and shifter.
  mth_modem_model mth_modem_model_i (.core_clk_i(core_clk_i),
    .arst_n_i(arst_n_i), .rts_i(rts_o), .cts_o(cts_i),
    .tx_start_i(tx_start_o), .tx_data_i(tx_data_o), .tx_done_o(tx_done_i),
    .loop_i(loop), .hold_cts_i(hold), .last_char_o(last_char),
    .sent_o(sent));

  // Clock of 20 ns period.
  initial begin
    core_clk_i = 1'b0;
    forever #10 core_clk_i = ~core_clk_i;
  end

  // Cycle counter, also cutting a hang short.
  always @(posedge core_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      mismatches = mismatches + 1;
      complete_run();
    end
  end

  // Compares a value with its expectation and counts the outcome.
  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    checked = checked + 1;
    if (got !== exp) begin
      mismatches = mismatches + 1;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_val

  // One-cycle register write.
  task automatic wr_reg(input logic [4:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wr_data_i <= d;
    @(posedge core_clk_i);
    wr_i <= 1'b0;
  endtask : wr_reg

  // One-cycle register read; data are taken in the following cycle.
  task automatic rd_reg(input logic [4:0] a);
    @(posedge core_clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge core_clk_i);
    rd_i <= 1'b0;
    #1;
    rv = rd_data_o;
  endtask : rd_reg

  // Waits until the transmit slot is free again.
  task automatic wait_free();
    do rd_reg(REG_STATUS); while (rv[0] !== 1'b1);
  endtask : wait_free

  // Prints the counts and the verdict, then ends the run.
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : complete_run

  // Main sequence of tests.
  initial begin
    arst_n_i = 1'b0;
    {wr_i, rd_i, rx_valid_i, hold} = 4'h0;
    loop = 1'b1;
    addr_i = 5'h00;
    wr_data_i = 32'h0;
    rx_data_i = 8'h00;
    repeat (2) @(posedge core_clk_i);
    arst_n_i <= 1'b1;
    // Reset values and an unmapped place.
    rd_reg(REG_CTRL); `CHK(rv, 32'h0);
    rd_reg(REG_TIMING); `CHK(rv, 32'h2);
    rd_reg(REG_CHAR_US); `CHK(rv, CHAR_US_RST);
    rd_reg(5'h02); `CHK(rv, 32'h0);
    `CHK(rts_o, 1'b0);
    $display("Test reset values done");
    // Full duplex: line up at once, flow paused while clear-to-send is low.
    wr_reg(REG_IRQ_MASK, 32'h2);
    wr_reg(REG_TIMING, 32'h0);
    wr_reg(REG_CTRL, 32'h3);
    repeat (2) @(posedge core_clk_i);
    #1 `CHK(rts_o, 1'b1);
    wr_reg(REG_TX_DATA, 32'h011);
    `WAIT(sent == 8'h01);
    hold <= 1'b1;
    wait_free();
    wr_reg(REG_TX_DATA, 32'h122);
    repeat (30) @(posedge core_clk_i);
    #1 `CHK(sent, 8'h01);
    rd_reg(REG_STATUS); `CHK(rv, 32'h0c);
    hold <= 1'b0;
    `WAIT(irq_o === 1'b1);
    `CHK(last_char, 8'h22);
    `CHK(rts_o, 1'b1);
    rd_reg(REG_IRQ_STAT); `CHK(rv, 32'h2);
    $display("Test full duplex flow done");
    // Half duplex with delays: 3 chars of 4000 us settle, 2 chars post.
    wr_reg(REG_CTRL, 32'h1);
    repeat (2) @(posedge core_clk_i);
    #1 `CHK(rts_o, 1'b0);
    wr_reg(REG_CHAR_US, 32'h0fa0);
    wr_reg(REG_TIMING, 32'h0203);
    wr_reg(REG_TX_DATA, 32'h1a5);
    `WAIT(rts_o === 1'b1);
    t0 = cycles;
    `WAIT(tx_start_o === 1'b1);
    `CHK((cycles - t0 >= 100) && (cycles - t0 <= 112), 1'b1);
    `WAIT(tx_done_i === 1'b1);
    t0 = cycles;
    `WAIT(rts_o === 1'b0);
    `CHK((cycles - t0 >= 50) && (cycles - t0 <= 58), 1'b1);
    `CHK(last_char, 8'ha5);
    `CHK(irq_o, 1'b1);
    rd_reg(REG_IRQ_STAT); `CHK(rv, 32'h2);
    @(posedge core_clk_i);
    #1 `CHK(irq_o, 1'b0);
    `CHK(rd_data_o, 32'h0);
    $display("Test half duplex delays done");
    // Missing clear-to-send: error after the 100 ms wait, nothing sent.
    hold <= 1'b1;
    wr_reg(REG_IRQ_MASK, 32'h1);
    wr_reg(REG_TX_DATA, 32'h177);
    t0 = cycles;
    `WAIT(irq_o === 1'b1);
    `CHK((cycles - t0 >= 500) && (cycles - t0 <= 515), 1'b1);
    `CHK(sent, 8'h03);
    rd_reg(REG_IRQ_STAT); `CHK(rv, 32'h1);
    $display("Test missing clear-to-send done");
    // Receive side takes a character even with the handshake low.
    wr_reg(REG_IRQ_MASK, 32'h4);
    @(posedge core_clk_i);
    rx_valid_i <= 1'b1;
    rx_data_i <= 8'h5a;
    @(posedge core_clk_i);
    rx_valid_i <= 1'b0;
    `WAIT(irq_o === 1'b1);
    rd_reg(REG_RX_DATA); `CHK(rv, 32'h5a);
    rd_reg(REG_IRQ_STAT); `CHK(rv, 32'h4);
    $display("Test receive done");
    complete_run();
  end
endmodule : testbench
